// ### core/ue0_regs.svh
// Register offsets, field positions and reset values of the endpoint-zero block
`ifndef UE0_REGS_SVH
`define UE0_REGS_SVH

// USB register space offsets seen over the link
`define UE0_ADDR_INDEX      8'h0E
`define UE0_ADDR_CSR        8'h11
`define UE0_ADDR_CNT        8'h16
`define UE0_EP0_INDEX       4'h0

// Reset values
`define UE0_CSR_RESET       8'h00
`define UE0_CNT_RESET       8'h00

// Field positions of endpoint0_control_status
`define UE0_B_SRV_SETUP_END 7
`define UE0_B_SRV_OUT_READY 6
`define UE0_B_SEND_STALL    5
`define UE0_B_SETUP_END     4
`define UE0_B_DATA_END      3
`define UE0_B_SENT_STALL    2
`define UE0_B_IN_READY      1
`define UE0_B_OUT_READY     0

// Only legal SETUP data length
`define UE0_SETUP_LEN       7'h08

// Avalon-MM byte offsets of the controller registers
`define UE0_AV_CMD          4'h0
`define UE0_AV_STAT         4'h4
`define UE0_AV_ISTAT        4'h8
`define UE0_AV_IMASK        4'hC

// Command register fields
`define UE0_CMD_WRITE       16

// Interrupt status and mask bits
`define UE0_IRQ_EP0         0
`define UE0_IRQ_DONE        1

`endif

// ### core/ue0_pkg.sv
// Types shared by both ends of the endpoint-zero link
package ue0_pkg;

  // Endpoint zero transfer direction tracking
  typedef enum logic [1:0] {UE0_IDLE, UE0_TX, UE0_RX} ue0_mode_type;

  // Device end state
  typedef struct packed {
    ue0_mode_type mode;
    logic         setupEnd;
    logic         outReady;
    logic         sendStall;
    logic         data_end_a;
    logic         sentStall;
    logic         inReady;
    logic         stallPend;
    logic         lastSetup;
    logic [3:0]   index;
    logic [6:0]   count;
    logic [7:0]   rdata;
    logic         evt;
  } ue0_dev_type;

  // Controller sequencer states
  typedef enum logic [1:0] {CT_IDLE, CT_INDEX, CT_ACCESS, CT_CAPTURE} ue0_ctl_state_type;

  // Controller end state
  typedef struct packed {
    ue0_ctl_state_type st;
    logic [7:0]        cmdAddr;
    logic [7:0]        cmdData;
    logic              cmdWrite;
    logic [7:0]        busAddr;
    logic [7:0]        busWdata;
    logic [7:0]        rdData;
    logic [1:0]        istat;
    logic [1:0]        imask;
    logic              ackQ;
    logic [31:0]       readdata;
  } ue0_ctl_type;

endpackage : ue0_pkg

// ### core/ue0_link_if.sv
// Register link between the controller and the endpoint-zero device
`timescale 1ns/1ps
interface ue0_link_if;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       ep0Event;

  // Endpoint-zero device end
  modport dev (
    input  regAddr,
    input  regWdata,
    input  regWr,
    input  regRd,
    output regRdata,
    output ep0Event
  );

  // Controller end
  modport ctl (
    output regAddr,
    output regWdata,
    output regWr,
    output regRd,
    input  regRdata,
    input  ep0Event
  );
endinterface : ue0_link_if

// ### core/ue0_ep0_csr.sv
// Endpoint-zero control/status flags and received byte count
`timescale 1ns/1ps
`include "ue0_regs.svh"

module ue0_ep0_csr import ue0_pkg::*; (
  input  wire logic       clk,
  input  wire logic       arst_n,
  ue0_link_if.dev         link,
  input  wire logic       sieTokSetup,
  input  wire logic       sieTokIn,
  input  wire logic       sieTokOut,
  input  wire logic       sieRxDone,
  input  wire logic [6:0] sieRxCount,
  input  wire logic       sieTooLong,
  input  wire logic       sieInSent,
  input  wire logic       sieStatusDone,
  input  wire logic       sieStallSent,
  output logic            respStall,
  output logic            inReady,
  output logic            outReady,
  output logic            data_end_a,
  output logic [6:0]      rxCount
);

  ue0_dev_type state_q;
  ue0_dev_type state_d;

  // Next-state logic for every flag, the index and the read path
  always_comb begin : nextState
    logic csrSel;
    logic csrWr;
    logic setSue;
    logic autoStall;
    logic rxOk;
    logic clrInr;
    logic clrDe;
    logic evt;
    csrSel    = 1'b0;
    csrWr     = 1'b0;
    setSue    = 1'b0;
    autoStall = 1'b0;
    rxOk      = 1'b0;
    clrInr    = 1'b0;
    clrDe     = 1'b0;
    evt       = 1'b0;
    state_d   = state_q;

    // Control register reachable only with index zero
    csrSel = (link.regAddr == `UE0_ADDR_CSR) &&
             (state_q.index == `UE0_EP0_INDEX);
    csrWr  = link.regWr && csrSel;

    // Wrong-length SETUP data is dropped silently
    rxOk = sieRxDone &&
           !(state_q.lastSetup && (sieRxCount != `UE0_SETUP_LEN));

    // Token tracking: transmit and receive modes
    if (sieTokSetup) begin
      if ((state_q.mode != UE0_IDLE) && !state_q.data_end_a) begin
        setSue = 1'b1;
      end
      state_d.mode      = UE0_IDLE;
      state_d.lastSetup = 1'b1;
    end else if (sieTokIn) begin
      if ((state_q.mode == UE0_RX) && !state_q.data_end_a) begin
        setSue = 1'b1;
      end
      // IN after the last packet of an IN data phase
      if ((state_q.mode == UE0_TX) && state_q.data_end_a && !state_q.inReady) begin
        autoStall = 1'b1;
      end
      state_d.mode      = UE0_TX;
      state_d.lastSetup = 1'b0;
    end else if (sieTokOut) begin
      if ((state_q.mode == UE0_TX) && !state_q.data_end_a) begin
        setSue = 1'b1;
      end
      // OUT after software closed the OUT data phase
      if ((state_q.mode == UE0_RX) && state_q.data_end_a) begin
        autoStall = 1'b1;
      end
      state_d.mode      = UE0_RX;
      state_d.lastSetup = 1'b0;
    end

    // Oversized packet is answered with a stall
    if (sieTooLong) begin
      autoStall = 1'b1;
    end

    // A transfer cut short also ends the data phase
    if (setSue) begin
      clrDe = 1'b1;
      evt   = 1'b1;
    end

    // Packet landed in the FIFO
    if (rxOk) begin
      state_d.count = sieRxCount;
      evt           = 1'b1;
      if (state_q.inReady) begin
        clrInr = 1'b1;
      end
    end

    // IN packet went out
    if (sieInSent) begin
      clrInr = 1'b1;
      evt    = 1'b1;
    end

    // Status stage finished
    if (sieStatusDone) begin
      clrDe        = 1'b1;
      state_d.mode = UE0_IDLE;
      evt          = 1'b1;
    end

    // Stall handshake went out
    if (sieStallSent) begin
      clrDe        = 1'b1;
      state_d.mode = UE0_IDLE;
      evt          = 1'b1;
    end

    // Sticky flags, hardware set ahead of software clear
    state_d.setupEnd = setSue |
      (state_q.setupEnd & ~(csrWr & link.regWdata[`UE0_B_SRV_SETUP_END]));
    state_d.outReady = rxOk |
      (state_q.outReady & ~(csrWr & link.regWdata[`UE0_B_SRV_OUT_READY]));
    state_d.sentStall = sieStallSent |
      (state_q.sentStall & ~(csrWr & ~link.regWdata[`UE0_B_SENT_STALL]));

    // Software-driven bits with hardware self-clear
    state_d.sendStall = csrWr ? link.regWdata[`UE0_B_SEND_STALL] :
                        (state_q.sendStall & ~sieStallSent);
    state_d.data_end_a   = csrWr ? link.regWdata[`UE0_B_DATA_END] :
                        (state_q.data_end_a & ~clrDe);
    state_d.inReady   = csrWr ? link.regWdata[`UE0_B_IN_READY] :
                        (state_q.inReady & ~clrInr);

    // Hardware stall waits until it has been sent
    state_d.stallPend = autoStall | (state_q.stallPend & ~sieStallSent);

    // Index register
    if (link.regWr && (link.regAddr == `UE0_ADDR_INDEX)) begin
      state_d.index = link.regWdata[3:0];
    end

    // Read data registered one edge after the strobe
    if (link.regRd) begin
      unique case (link.regAddr)
        `UE0_ADDR_CSR: begin
          state_d.rdata = csrSel ? {1'b0,
                                    1'b0,
                                    state_q.sendStall,
                                    state_q.setupEnd,
                                    state_q.data_end_a,
                                    state_q.sentStall,
                                    state_q.inReady,
                                    state_q.outReady} : 8'h00;
        end
        `UE0_ADDR_CNT: begin
          state_d.rdata = {1'b0, state_q.count};
        end
        `UE0_ADDR_INDEX: begin
          state_d.rdata = {4'h0, state_q.index};
        end
        default: begin
          state_d.rdata = 8'h00;
        end
      endcase
    end

    state_d.evt = evt;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin : stateReg
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state
  assign link.regRdata = state_q.rdata;
  assign link.ep0Event = state_q.evt;
  assign respStall     = state_q.sendStall | state_q.stallPend;
  assign inReady       = state_q.inReady;
  assign outReady      = state_q.outReady;
  assign data_end_a       = state_q.data_end_a;
  assign rxCount       = state_q.count;

endmodule : ue0_ep0_csr

// ### core/ue0_ctrl.sv
// Avalon-MM controller that reaches the endpoint-zero registers over the link
`timescale 1ns/1ps
`include "ue0_regs.svh"

module ue0_ctrl import ue0_pkg::*; (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  ue0_link_if.ctl          link
);

  ue0_ctl_type state_q;
  ue0_ctl_type state_d;

  // Bus slave, interrupt bits and link sequencer
  always_comb begin : nextState
    logic wrEff;
    logic done;
    logic busy;
    wrEff   = 1'b0;
    done    = 1'b0;
    busy    = 1'b0;
    state_d = state_q;
    busy    = (state_q.st != CT_IDLE);

    // One wait state, then the access completes
    wrEff = avs_write && state_q.ackQ;
    if ((avs_read || avs_write) && !state_q.ackQ) begin
      state_d.ackQ = 1'b1;
      if (avs_read) begin
        unique case (avs_address)
          `UE0_AV_CMD:   state_d.readdata = {15'h0000, state_q.cmdWrite,
                                             state_q.cmdData, state_q.cmdAddr};
          `UE0_AV_STAT:  state_d.readdata = {16'h0000, state_q.rdData, 7'h00, busy};
          `UE0_AV_ISTAT: state_d.readdata = {30'h00000000, state_q.istat};
          `UE0_AV_IMASK: state_d.readdata = {30'h00000000, state_q.imask};
          default:       state_d.readdata = 32'h00000000;
        endcase
      end
    end else begin
      state_d.ackQ = 1'b0;
    end

    // Link sequencer
    unique case (state_q.st)
      CT_IDLE: begin
      end
      CT_INDEX: begin
        state_d.st       = CT_ACCESS;
        state_d.busAddr  = state_q.cmdAddr;
        state_d.busWdata = state_q.cmdData;
      end
      CT_ACCESS: begin
        if (state_q.cmdWrite) begin
          state_d.st = CT_IDLE;
          done       = 1'b1;
        end else begin
          state_d.st = CT_CAPTURE;
        end
      end
      CT_CAPTURE: begin
        state_d.rdData = link.regRdata;
        state_d.st     = CT_IDLE;
        done           = 1'b1;
      end
    endcase

    // Command write starts an access when idle
    if (wrEff && (avs_address == `UE0_AV_CMD) && !busy) begin
      if (avs_byteenable[0]) begin
        state_d.cmdAddr = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        state_d.cmdData = avs_writedata[15:8];
      end
      if (avs_byteenable[2]) begin
        state_d.cmdWrite = avs_writedata[`UE0_CMD_WRITE];
      end
      if (state_d.cmdAddr == `UE0_ADDR_CSR) begin
        // Select endpoint zero before the control register
        state_d.st       = CT_INDEX;
        state_d.busAddr  = `UE0_ADDR_INDEX;
        state_d.busWdata = {4'h0, `UE0_EP0_INDEX};
      end else begin
        state_d.st       = CT_ACCESS;
        state_d.busAddr  = state_d.cmdAddr;
        state_d.busWdata = state_d.cmdData;
      end
    end

    // Mask register
    if (wrEff && (avs_address == `UE0_AV_IMASK) && avs_byteenable[0]) begin
      state_d.imask = avs_writedata[1:0];
    end

    // Sticky status, set wins over write-one-to-clear
    state_d.istat = state_q.istat;
    if (wrEff && (avs_address == `UE0_AV_ISTAT) && avs_byteenable[0]) begin
      state_d.istat = state_q.istat & ~avs_writedata[1:0];
    end
    if (link.ep0Event) begin
      state_d.istat[`UE0_IRQ_EP0] = 1'b1;
    end
    if (done) begin
      state_d.istat[`UE0_IRQ_DONE] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin : stateReg
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Bus and link outputs
  assign avs_waitrequest = (avs_read || avs_write) && !state_q.ackQ;
  assign avs_readdata    = state_q.readdata;
  assign irq             = |(state_q.istat & state_q.imask);
  assign link.regAddr    = state_q.busAddr;
  assign link.regWdata   = state_q.busWdata;
  assign link.regWr      = (state_q.st == CT_INDEX) ||
                           ((state_q.st == CT_ACCESS) && state_q.cmdWrite);
  assign link.regRd      = (state_q.st == CT_ACCESS) && !state_q.cmdWrite;

endmodule : ue0_ctrl

// ### tb/ue0_link_asserts.sv
// Link checker between the controller and the endpoint-zero device
`timescale 1ns/1ps
`include "ue0_regs.svh"

module ue0_link_asserts (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       ep0Event
);
  logic [2:0] clrSeen_q;
  logic [2:0] clrSeen_d;
  logic       csrWr;
  logic       csrRd;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Control register strobes on the link
  assign csrWr = regWr && (regAddr == `UE0_ADDR_CSR);
  assign csrRd = regRd && (regAddr == `UE0_ADDR_CSR);

  // Flags cleared by software, forgotten on any event
  always_comb begin
    clrSeen_d = ep0Event ? 3'h0 : clrSeen_q;
    if (csrWr) begin
      clrSeen_d[0] = clrSeen_d[0] | regWdata[7];
      clrSeen_d[1] = clrSeen_d[1] | regWdata[6];
      clrSeen_d[2] = clrSeen_d[2] | !regWdata[2];
    end
  end

  // Tracking register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) clrSeen_q <= 3'h0;
    else clrSeen_q <= clrSeen_d;
  end

  AST_STROBE_EXCL: assert property (!(regWr && regRd))
    else $error("link read and write strobes overlap");
  AST_RD_PULSE: assert property (regRd |=> !regRd)
    else $error("link read strobe longer than one cycle");
  AST_RDATA_HOLD: assert property (!$past(regRd) |-> $stable(regRdata))
    else $error("link read data moved without a read");
  AST_CSR_STROBE_BITS: assert property (csrRd |=> regRdata[7:6] == 2'h0)
    else $error("serviced bits read as one");
  AST_CNT_TOP_BIT: assert property (regRd && regAddr == `UE0_ADDR_CNT |=> !regRdata[7])
    else $error("count top bit read as one");
  AST_INDEX_FIRST: assert property ((csrWr || csrRd) |-> $past(regWr) &&
    $past(regAddr) == `UE0_ADDR_INDEX && $past(regWdata) == 8'h00)
    else $error("control access without index zero before it");
  AST_SETUP_END_CLR: assert property (csrRd && clrSeen_q[0] && !ep0Event |=> !regRdata[4])
    else $error("setup end still set after service");
  AST_OUT_READY_CLR: assert property (csrRd && clrSeen_q[1] && !ep0Event |=> !regRdata[0])
    else $error("out ready still set after service");
  AST_SENT_STALL_CLR: assert property (csrRd && clrSeen_q[2] && !ep0Event |=> !regRdata[2])
    else $error("sent stall still set after clear");

  // Main scenarios
  CV_CSR_WRITE: cover property (csrWr);
  CV_SETUP_END_READ: cover property (csrRd ##1 regRdata[4]);
  CV_EVENT: cover property (ep0Event);
  CV_CNT_READ: cover property (regRd && regAddr == `UE0_ADDR_CNT);
endmodule : ue0_link_asserts

// ### tb/test_usb_endpoint0_control_status.sv
// Bench joining controller and endpoint-zero device over the link
`timescale 1ns/1ps
`include "ue0_regs.svh"

module test_usb_endpoint0_control_status import ue0_pkg::*;;
  logic        clk;
  logic        arst_n;
  logic [3:0]  avAddr;
  logic        avRd;
  logic        avWr;
  logic [31:0] avWdata;
  logic [31:0] avRdata;
  logic        avWait;
  logic        irq;
  logic [7:0]  sie;
  logic [6:0]  rxCnt;
  logic        respStall;
  logic        inReady;
  logic        outReady;
  logic        data_end_a;
  logic [6:0]  rxCount;
  logic [11:0] prt;
  logic [31:0] q;
  int          n_errors;
  int          tests_run;

  ue0_link_if ue0_link_if_i ();
  ue0_ctrl ue0_ctrl_i (.clk(clk), .arst_n(arst_n), .avs_address(avAddr), .avs_read(avRd),
    .avs_write(avWr), .avs_writedata(avWdata), .avs_byteenable(4'hF),
    .avs_readdata(avRdata), .avs_waitrequest(avWait), .irq(irq), .link(ue0_link_if_i));
  ue0_ep0_csr ue0_ep0_csr_i (.clk(clk), .arst_n(arst_n), .link(ue0_link_if_i),
    .sieTokSetup(sie[0]), .sieTokIn(sie[1]), .sieTokOut(sie[2]), .sieRxDone(sie[3]),
    .sieRxCount(rxCnt), .sieTooLong(sie[4]), .sieInSent(sie[5]), .sieStatusDone(sie[6]),
    .sieStallSent(sie[7]), .respStall(respStall), .inReady(inReady), .outReady(outReady),
    .data_end_a(data_end_a), .rxCount(rxCount));
  ue0_link_asserts ue0_link_asserts_i (.clk(clk), .arst_n(arst_n),
    .regAddr(ue0_link_if_i.regAddr), .regWdata(ue0_link_if_i.regWdata),
    .regWr(ue0_link_if_i.regWr), .regRd(ue0_link_if_i.regRd),
    .regRdata(ue0_link_if_i.regRdata), .ep0Event(ue0_link_if_i.ep0Event));

  // Observed outputs in one word
  assign prt = {irq, respStall, inReady, outReady, data_end_a, rxCount};

  // Clock
  always #20 clk = ~clk;

  task automatic end_of_test;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One Avalon access, held until waitrequest is sampled low at a rising edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int   n;
    logic w;
    avAddr <= a;
    avWdata <= d;
    avWr <= wr;
    avRd <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      w = avWait;
      q = avRdata;
      n++;
    end while (w !== 1'b0 && n < 20);
    avWr <= 1'b0;
    avRd <= 1'b0;
    if (w !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
    @(posedge clk);
  endtask : av

  // Device register access through the command register, then wait idle
  task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    av(1'b1, `UE0_AV_CMD, {15'h0000, wr, d, a});
    n = 0;
    do begin
      av(1'b0, `UE0_AV_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
  endtask : dev

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    dev(1'b0, a, 8'h00);
    chk({24'h0, q[15:8]}, {24'h0, exp});
  endtask : rd

  // One-cycle pulse on the packet engine inputs
  task automatic pulse(input logic [7:0] v, input logic [6:0] c);
    sie <= v;
    rxCnt <= c;
    @(posedge clk);
    sie <= 8'h00;
    @(posedge clk);
  endtask : pulse

  task automatic ports(input logic [11:0] exp);
    @(negedge clk);
    chk({20'h0, prt}, {20'h0, exp});
    @(posedge clk);
  endtask : ports

  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    avAddr = 4'h0;
    avRd = 1'b0;
    avWr = 1'b0;
    avWdata = 32'h0;
    sie = 8'h00;
    rxCnt = 7'h00;
    n_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`UE0_ADDR_CSR, 8'h00);
    rd(`UE0_ADDR_CNT, 8'h00);
    ports(12'h000);
    av(1'b1, 4'h2, 32'hFFFF_FFFF);
    av(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    pulse(8'h01, 7'h00);
    pulse(8'h08, 7'h05);
    rd(`UE0_ADDR_CSR, 8'h00);
    rd(`UE0_ADDR_CNT, 8'h00);
    dev(1'b1, `UE0_ADDR_CSR, 8'h02);
    ports(12'h200);
    pulse(8'h01, 7'h00);
    pulse(8'h08, 7'h08);
    rd(`UE0_ADDR_CSR, 8'h01);
    rd(`UE0_ADDR_CNT, 8'h08);
    ports(12'h108);
    dev(1'b1, `UE0_ADDR_CNT, 8'hFF);
    rd(`UE0_ADDR_CNT, 8'h08);
    av(1'b0, `UE0_AV_ISTAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    av(1'b1, `UE0_AV_IMASK, 32'h1);
    ports(12'h908);
    av(1'b1, `UE0_AV_ISTAT, 32'h3);
    ports(12'h108);
    av(1'b1, `UE0_AV_IMASK, 32'h0);
    dev(1'b1, `UE0_ADDR_CSR, 8'hC0);
    rd(`UE0_ADDR_CSR, 8'h00);
    dev(1'b1, `UE0_ADDR_CSR, 8'h02);
    pulse(8'h02, 7'h00);
    pulse(8'h20, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h00);
    av(1'b0, `UE0_AV_ISTAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    pulse(8'h01, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h10);
    dev(1'b1, `UE0_ADDR_CSR, 8'h80);
    rd(`UE0_ADDR_CSR, 8'h00);
    dev(1'b1, `UE0_ADDR_CSR, 8'h20);
    rd(`UE0_ADDR_CSR, 8'h20);
    ports(12'h408);
    pulse(8'h80, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h04);
    dev(1'b1, `UE0_ADDR_CSR, 8'h04);
    rd(`UE0_ADDR_CSR, 8'h04);
    dev(1'b1, `UE0_ADDR_CSR, 8'h00);
    rd(`UE0_ADDR_CSR, 8'h00);
    pulse(8'h10, 7'h00);
    ports(12'h408);
    pulse(8'h80, 7'h00);
    ports(12'h008);
    dev(1'b1, `UE0_ADDR_CSR, 8'h0A);
    ports(12'h288);
    pulse(8'h02, 7'h00);
    pulse(8'h20, 7'h00);
    pulse(8'h40, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h00);
    // OUT data phase, then an OUT after data-end is stalled
    pulse(8'h04, 7'h00);
    pulse(8'h08, 7'h03);
    rd(`UE0_ADDR_CNT, 8'h03);
    dev(1'b1, `UE0_ADDR_CSR, 8'h48);
    pulse(8'h04, 7'h00);
    ports(12'h483);
    pulse(8'h80, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h04);
    // OUT token in transmit mode ends the transfer early
    pulse(8'h02, 7'h00);
    pulse(8'h04, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h14);
    // IN after the last IN packet is stalled
    dev(1'b1, `UE0_ADDR_CSR, 8'h88);
    pulse(8'h02, 7'h00);
    pulse(8'h02, 7'h00);
    ports(12'h483);
    pulse(8'h80, 7'h00);
    rd(`UE0_ADDR_CSR, 8'h04);
    end_of_test();
  end
endmodule : test_usb_endpoint0_control_status
